//--- inc/palette_idx_pkg.sv
// Constants and types shared by the palette index and mask logic
// Operation
// - Palette lookup index is the mask ANDed with each 8-bit pixel.
// - Mask bit 0 forces index bit low; mask bit 1 passes pixel bit.
// - State bits 1:0 show last index written: 00 write, 11 read.
// - After reset the state field reads 00.
// - State bits 7:2 always read zero.
// - Read index selects which of 256 colours the data port returns.
// - Read index increments on the data read at blue; data writes step the same sequencer.
// - Writing the read index cancels an unfinished palette write.
// - Write index selects which of 256 colours receives written data.
// - Write index increments on the data write at blue; data reads step the same sequencer.
// - Index and data port access works in every display mode.
// - Data port bytes go red, then green, then blue.
// - Writing either index returns the byte sequencer to red.
// - A colour is committed on the data write at blue; data reads step the same sequencer.
package palette_idx_pkg;
  localparam logic [15:0] MASK_ADDR     = 16'h03C6;
  localparam logic [15:0] STATE_ADDR    = 16'h03C7;
  localparam logic [15:0] RD_INDEX_ADDR = 16'h03C7;
  localparam logic [15:0] WR_INDEX_ADDR = 16'h03C8;
  localparam logic [15:0] DATA_ADDR     = 16'h03C9;
  localparam logic [1:0]  STATE_WRITE   = 2'h0;
  localparam logic [1:0]  STATE_READ    = 2'h3;
  localparam logic [7:0]  MASK_RESET    = 8'hFF;
  localparam logic [7:0]  INDEX_RESET   = 8'h00;
  localparam logic [5:0]  STATE_PAD     = 6'h00;
  typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} comp_t;
endpackage

//--- inc/byte_seq_if.sv
// Interface between the host register logic and the byte sequencer
`timescale 1ns/100ps
interface byte_seq_if;
  import palette_idx_pkg::*;
  logic  restart;
  logic  step;
  comp_t comp;
  logic  last;
  modport ctrl (output restart, output step, input comp, input last);
  modport seq  (input restart, input step, output comp, output last);
endinterface

//--- logic/byte_sequencer.sv
// Red, green, blue byte sequencer for the palette data port
`timescale 1ns/100ps
module byte_sequencer
  import palette_idx_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  byte_seq_if.seq   bus
);
  comp_t comp;
  comp_t next_comp;

  // Restart beats step so an index write always lands on red
  always_comb begin
    next_comp = comp;
    if (bus.restart) begin
      next_comp = COMP_RED;
    end else if (bus.step) begin
      unique case (comp)
        COMP_RED:   next_comp = COMP_GREEN;
        COMP_GREEN: next_comp = COMP_BLUE;
        COMP_BLUE:  next_comp = COMP_RED;
        default:    next_comp = COMP_RED; // Illegal code recovers
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      comp <= COMP_RED;
    end else begin
      comp <= next_comp;
    end
  end

  assign bus.comp = comp;
  assign bus.last = (comp == COMP_BLUE);
endmodule // byte_sequencer

//--- logic/vga_palette_index_mask.sv
// Host I/O registers, byte sequencing and pixel masking for the palette
`timescale 1ns/100ps
module vga_palette_index_mask
  import palette_idx_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [7:0]  io_wdata_in,
  output logic      [7:0]  io_rdata_out,
  input  wire logic        pix_valid_in,
  input  wire logic [7:0]  pix_data_in,
  output logic             lut_valid_out,
  output logic      [7:0]  lut_index_out,
  output logic             pal_rd_out,
  output logic      [7:0]  pal_rd_index_out,
  output logic      [1:0]  pal_rd_comp_out,
  input  wire logic [23:0] pal_rd_data_in,
  output logic             pal_wr_out,
  output logic      [7:0]  pal_wr_index_out,
  output logic      [23:0] pal_wr_data_out
);
  // Control and status between this block and the byte sequencer
  byte_seq_if sq ();

  ////////////////////////////////////////////////////////////////////////
  // Host-visible registers and the staging of a colour being written
  logic [7:0]  pixel_lookup_mask;
  logic [1:0]  last_index_written_state;
  logic [7:0]  palette_read_pointer;
  logic [7:0]  palette_write_pointer;
  logic [15:0] wr_hold;
  logic        wr_dir;
  logic [7:0]  rdata;
  logic        lut_valid;
  logic [7:0]  lut_index;
  logic        pal_wr;
  logic [23:0] pal_wr_data;

  // Next values, one for each register above
  logic [7:0]  next_mask;
  logic [1:0]  next_state;
  logic [7:0]  next_rd_ptr;
  logic [7:0]  next_wr_ptr;
  logic [15:0] next_wr_hold;
  logic        next_wr_dir;
  logic [7:0]  next_rdata;
  logic        next_lut_valid;
  logic [7:0]  next_lut_index;
  logic        next_pal_wr;
  logic [23:0] next_pal_wr_data;
  logic [7:0]  comp_byte;

  // One sequencer serves reads and writes alike, so a host that mixes
  // the two inside one colour gets bytes from both directions
  byte_sequencer u_seq (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .bus        (sq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of the I/O strobes; no display mode input, so access is open
  // in every mode
  logic wr_mask;
  logic wr_rx;
  logic wr_wx;
  logic wr_data;
  logic rd_data;
  // A read and a write of the data port in one cycle count as a write
  assign wr_mask = io_wr_in && (io_addr_in == MASK_ADDR);
  assign wr_rx   = io_wr_in && (io_addr_in == RD_INDEX_ADDR);
  assign wr_wx   = io_wr_in && (io_addr_in == WR_INDEX_ADDR);
  assign wr_data = io_wr_in && (io_addr_in == DATA_ADDR);
  assign rd_data = io_rd_in && (io_addr_in == DATA_ADDR) && !io_wr_in;

  // Any index write restarts the sequencer; a data access steps it
  assign sq.restart = wr_rx || wr_wx;
  assign sq.step    = wr_data || rd_data;

  // Component of the current colour returned for a data read
  always_comb begin
    unique case (sq.comp)
      COMP_RED:   comp_byte = pal_rd_data_in[23:16];
      COMP_GREEN: comp_byte = pal_rd_data_in[15:8];
      default:    comp_byte = pal_rd_data_in[7:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    next_mask        = pixel_lookup_mask;
    next_state       = last_index_written_state;
    next_rd_ptr      = palette_read_pointer;
    next_wr_ptr      = palette_write_pointer;
    next_wr_hold     = wr_hold;
    next_wr_dir      = wr_dir;
    next_pal_wr      = 1'b0;
    next_pal_wr_data = pal_wr_data;
    next_rdata       = rdata;
    // Mask writes are independent of index and data traffic
    if (wr_mask) begin
      next_mask = io_wdata_in;
    end
    // Index writes take priority over data traffic in the same cycle
    if (wr_rx) begin
      next_rd_ptr = io_wdata_in;
      next_state  = STATE_READ;
      next_wr_dir = 1'b0; // Pending bytes dropped
    end else if (wr_wx) begin
      next_wr_ptr = io_wdata_in;
      next_state  = STATE_WRITE;
      next_wr_dir = 1'b0;
    end else if (wr_data) begin
      // Bytes are staged; only the third one commits
      unique case (sq.comp)
        COMP_RED:   next_wr_hold[15:8] = io_wdata_in;
        COMP_GREEN: next_wr_hold[7:0]  = io_wdata_in;
        default:    next_wr_hold       = wr_hold;
      endcase
      next_wr_dir = 1'b1;
      if (sq.last) begin
        next_pal_wr      = 1'b1;
        next_pal_wr_data = {wr_hold, io_wdata_in};
        next_wr_ptr      = palette_write_pointer + 8'h01;
        next_wr_dir      = 1'b0;
      end
    end else if (rd_data) begin
      next_rdata = comp_byte;
      if (sq.last) begin
        next_rd_ptr = palette_read_pointer + 8'h01;
      end
    end
    // Reads other than the data port; the write pointer reads back as zero
    // and the read index address returns the state, so no pointer leaks
    if (io_rd_in && !rd_data) begin
      unique case (io_addr_in)
        MASK_ADDR:  next_rdata = pixel_lookup_mask;
        STATE_ADDR: next_rdata = {STATE_PAD, last_index_written_state};
        default:    next_rdata = 8'h00; // Write-only or unmapped
      endcase
    end
  end

  // Register stage; the mask has no defined reset, all ones passes pixels
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pixel_lookup_mask        <= MASK_RESET;
      last_index_written_state <= STATE_WRITE;
      palette_read_pointer     <= INDEX_RESET;
      palette_write_pointer    <= INDEX_RESET;
      wr_hold                  <= 16'h0000;
      wr_dir                   <= 1'b0;
      rdata                    <= 8'h00;
      pal_wr                   <= 1'b0;
      pal_wr_data              <= 24'h000000;
    end else begin
      pixel_lookup_mask        <= next_mask;
      last_index_written_state <= next_state;
      palette_read_pointer     <= next_rd_ptr;
      palette_write_pointer    <= next_wr_ptr;
      wr_hold                  <= next_wr_hold;
      wr_dir                   <= next_wr_dir;
      rdata                    <= next_rdata;
      pal_wr                   <= next_pal_wr;
      pal_wr_data              <= next_pal_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel path: one cycle of latency, mask applied bit for bit
  // The mask is used as it stands at the pixel's own clock edge
  always_comb begin
    next_lut_valid = pix_valid_in;
    next_lut_index = pix_data_in & pixel_lookup_mask;
  end

  // Register the lookup so the index output comes from a flip-flop
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lut_valid <= 1'b0;
      lut_index <= 8'h00;
    end else begin
      lut_valid <= next_lut_valid;
      lut_index <= next_lut_index;
    end
  end

  // Commit index lags the pointer, so keep the index that was used
  // because the pointer has already moved on in the commit cycle
  logic [7:0] wr_index_q;
  logic [7:0] next_wr_index_q;
  always_comb begin
    next_wr_index_q = (wr_data && sq.last) ? palette_write_pointer
                                           : wr_index_q;
  end
  // Holds the commit index until the next completed colour
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_index_q <= INDEX_RESET;
    end else begin
      wr_index_q <= next_wr_index_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign io_rdata_out     = rdata;
  assign lut_valid_out    = lut_valid;
  assign lut_index_out    = lut_index;
  assign pal_wr_out       = pal_wr;
  assign pal_wr_index_out = wr_index_q;
  assign pal_wr_data_out  = pal_wr_data;
  // Storage lookup address is the live pointer; storage is asynchronous
  assign pal_rd_out       = rd_data;
  assign pal_rd_index_out = palette_read_pointer;
  assign pal_rd_comp_out  = sq.comp;
  // wr_dir shows a write in progress; kept for future status use
  logic unused_dir;
  assign unused_dir = wr_dir;
endmodule // vga_palette_index_mask

//--- sim/palette_idx_checker.sv
// Port-level assertions for the palette index and mask block
`timescale 1ns/100ps
module palette_idx_checker
  import palette_idx_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic [15:0] io_addr_in,
  input wire logic        io_wr_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_wdata_in,
  input wire logic [7:0]  io_rdata_out,
  input wire logic        pix_valid_in,
  input wire logic [7:0]  pix_data_in,
  input wire logic        lut_valid_out,
  input wire logic [7:0]  lut_index_out,
  input wire logic        pal_rd_out,
  input wire logic [7:0]  pal_rd_index_out,
  input wire logic [1:0]  pal_rd_comp_out,
  input wire logic        pal_wr_out,
  input wire logic [7:0]  pal_wr_index_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Decoded strobes keep the properties short
  wire dw = io_wr_in && io_addr_in == DATA_ADDR;
  wire ww = io_wr_in && io_addr_in == WR_INDEX_ADDR;
  wire rw = io_wr_in && io_addr_in == RD_INDEX_ADDR;
  wire sr = io_rd_in && !io_wr_in && io_addr_in == STATE_ADDR;
  a_lut_valid: assert property (pix_valid_in |=> lut_valid_out)
    else $error("lookup valid missing");
  a_lut_masked: assert property (
    pix_valid_in |=> (lut_index_out & ~$past(pix_data_in)) == 8'h00)
    else $error("lookup index has a bit the pixel lacked");
  a_state_pad: assert property (
    sr |=> io_rdata_out[7:2] == STATE_PAD) else $error("state pad set");
  a_state_read: assert property (
    rw ##1 !io_wr_in ##1 sr |=> io_rdata_out[1:0] == STATE_READ)
    else $error("state not read code");
  a_wr_commit: assert property (
    ww ##1 !io_wr_in ##1 dw ##1 !io_wr_in ##1 dw ##1 !io_wr_in ##1 dw
    |=> pal_wr_out && pal_wr_index_out == $past(io_wdata_in, 7))
    else $error("commit missing or wrong index");
  a_rd_load: assert property (
    rw |=> pal_rd_index_out == $past(io_wdata_in)
    && pal_rd_comp_out == COMP_RED) else $error("read index load");
  a_rd_step: assert property (
    pal_rd_out && pal_rd_comp_out == COMP_RED |=>
    pal_rd_comp_out == COMP_GREEN && $stable(pal_rd_index_out))
    else $error("red not followed by green");
  a_rd_wrap: assert property (
    pal_rd_out && pal_rd_comp_out == COMP_BLUE |=>
    pal_rd_index_out == $past(pal_rd_index_out) + 8'h01)
    else $error("read index not advanced");
endmodule // palette_idx_checker
////////////////////////////////////////
bind vga_palette_index_mask palette_idx_checker chk_i (.*);

//--- sim/tb.sv
// Self-checking bench for the palette index and mask block
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
  import palette_idx_pkg::*;
  logic        ref_clk_in = 0, rstn_in = 0, io_wr_in = 0, io_rd_in = 0;
  logic [15:0] io_addr_in = 16'h0000;
  logic [7:0]  io_wdata_in = 8'h00, pix_data_in = 8'h00, io_rdata_out;
  logic        pix_valid_in = 0, lut_valid_out, pal_rd_out, pal_wr_out;
  logic [7:0]  lut_index_out, pal_rd_index_out, pal_wr_index_out;
  logic [1:0]  pal_rd_comp_out;
  logic [23:0] pal_rd_data_in, pal_wr_data_out, pal [256];
  logic [31:0] q [$], ex;
  logic [7:0]  mask = MASK_RESET, rp = 8'h00, wp = 8'h00, r = 8'h16;
  logic [7:0]  stg [3];
  logic [1:0]  st = STATE_WRITE;
  int          sq = 0, mismatches = 0, n_tests = 0;
  vga_palette_index_mask vga_palette_index_mask_i (.*);
  // Clock, and storage that answers reads at once
  always #2.5 ref_clk_in = ~ref_clk_in;
  assign pal_rd_data_in = pal[pal_rd_index_out];
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task report_and_stop;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One host access; the model shares one sequencer for reads and writes
  task acc(input bit w, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = 8'h00;
    @(negedge ref_clk_in);
    {io_addr_in, io_wr_in, io_rd_in, io_wdata_in} = {a, w, !w, d};
    if (w) case (a)
      MASK_ADDR: mask = d;
      RD_INDEX_ADDR: {rp, st, sq} = {d, STATE_READ, 32'd0};
      WR_INDEX_ADDR: {wp, st, sq} = {d, STATE_WRITE, 32'd0};
      DATA_ADDR: begin
        stg[sq] = d;
        if (sq == 2) begin
          pal[wp] = {stg[0], stg[1], d};
          q.push_back({wp, stg[0], stg[1], d});
          wp++;
          sq = 0;
        end else sq++;
      end
      default: ;
    endcase else case (a)
      MASK_ADDR: e = mask;
      STATE_ADDR: e = {STATE_PAD, st};
      DATA_ADDR: begin
        e = pal[rp][23 - 8 * sq -: 8];
        sq = (sq + 1) % 3;
        if (sq == 0) rp++;
      end
      default: ;
    endcase
    @(negedge ref_clk_in);
    {io_wr_in, io_rd_in} = 2'h0;
    if (!w) `CHK(io_rdata_out, e)
  endtask
  task px(input logic [7:0] p);
    @(negedge ref_clk_in);
    {pix_valid_in, pix_data_in} = {1'b1, p};
    @(negedge ref_clk_in);
    pix_valid_in = 0;
    `CHK({lut_valid_out, lut_index_out}, {1'b1, p & mask})
  endtask
  // Every commit must match the oldest completed colour
  always @(negedge ref_clk_in) if (pal_wr_out === 1'b1) begin
    ex = q.size() ? q.pop_front() : 32'hX;
    `CHK({pal_wr_index_out, pal_wr_data_out}, ex)
  end
  // Watchdog sized well above the expected run of about a thousand cycles
  initial begin
    #40000;
    mismatches++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) pal[i] = 24'(i * 24'h030507);
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rstn_in = 1;
    acc(0, STATE_ADDR, 8'h00);
    acc(0, MASK_ADDR, 8'h00);
    acc(0, WR_INDEX_ADDR, 8'h00);
    acc(0, 16'h03C5, 8'h00);
    // Masked pixels, new mask every eighth pixel
    for (int i = 0; i < 48; i++) begin
      r = nx(r);
      if (i % 8 == 0) acc(1, MASK_ADDR, r);
      px(nx(r));
    end
    // Two colours across the top, then an abandoned partial one
    acc(1, WR_INDEX_ADDR, 8'hFE);
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      acc(1, DATA_ADDR, r);
    end
    acc(1, RD_INDEX_ADDR, 8'hFE);
    acc(0, STATE_ADDR, 8'h00);
    for (int i = 0; i < 7; i++) acc(0, DATA_ADDR, 8'h00);
    acc(0, STATE_ADDR, 8'h00);
    acc(1, WR_INDEX_ADDR, 8'h10);
    for (int i = 0; i < 3; i++) acc(1, DATA_ADDR, 8'hA0 + 8'(i));
    // Random mix of every register and direction
    repeat (400) begin
      r = nx(r);
      acc(r[7], 16'h03C5 + 16'(r[2:0] % 5), nx(r));
    end
    repeat (3) @(negedge ref_clk_in);
    `CHK(q.size(), 0)
    report_and_stop();
  end
endmodule // tb
